// [rtl/spf_framer.sv]
// Purpose: Builds, stuffs, sends and retries packets; unstuffs and checks them.
// Assumes: A serial character unit moves link bytes over valid/ready.
// Notes:   Received message bytes reach the user before the packet is checked.
//
// How it works
// - Packet is start, two length bytes, 6..507 message bytes, checksum, end.
// - Length counts message bytes only, sent high byte first.
// - Responses are a code byte followed by the end byte, nothing else.
// - Checksum is low eight bits of the sum of length and message bytes.
// - Length and checksum come from unstuffed content; stuffing changes neither.
// - Sender escapes 02, 03 and FF as FF F2, FF F3, FF FF.
// - Receiver turns FF F2, FF F3, FF FF back into 02, 03, FF.
// - Start, end and response code bytes are never stuffed.
// - Escape followed by any other byte is an error answered by NAK.
// - After the end byte a 5 second wait; silence resends, up to 3 times.
// - NAK retries 3 times; busy retries 10 times after 10 seconds each.
// - When retries run out the send ends with an error.
// - No new packet starts before a response or the timeout.
// - Late or duplicate responses outside the wait are ignored.
// - Retry counts and waits are module parameters.
// - Codes are ACK 06, NAK 15, busy 1A, each with the end byte.
// - Bytes before a start byte are dropped, except response codes.
// - At the end byte length, checksum and escape errors decide NAK or ACK.
// - Link bytes are 8-bit characters of the external serial unit.
`timescale 1ns/1ps
module spf_framer
   import spf_pkg::*;
#(
   parameter int unsigned RespWaitCyc    = RESP_WAIT_CYC,
   parameter int unsigned BusyWaitCyc    = BUSY_WAIT_CYC,
   parameter logic [3:0]  NakRetries     = NAK_RETRIES,
   parameter logic [3:0]  TimeoutRetries = TIMEOUT_RETRIES,
   parameter logic [3:0]  BusyRetries    = BUSY_RETRIES,
   parameter int          RxBufDepth     = 2
) (
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic [7:0] txMsgData,
   input  wire logic       txMsgValid,
   input  wire logic       txMsgLast,
   output logic            txMsgReady,
   output logic [7:0]      linkTxData,
   output logic            linkTxValid,
   input  wire logic       linkTxReady,
   input  wire logic [7:0] linkRxData,
   input  wire logic       linkRxValid,
   output logic            linkRxReady,
   output logic [7:0]      rxMsgData,
   output logic            rxMsgValid,
   input  wire logic       rxMsgReady,
   output logic            evSendDone,
   output logic            evSendFail,
   output logic            evRxGood,
   output logic            evChecksumErr,
   output logic            evLengthErr,
   output logic            evEscapeErr
);

   spf_byte_if #(.W(8)) bufIn ();
   spf_byte_if #(.W(8)) bufOut ();

   spf_pair_buf #(.W(8), .DEPTH(RxBufDepth)) uRxBuf (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .inSide  (bufIn),
      .outSide (bufOut)
   );

   spf_tx_state_t txState_reg;
   spf_rx_state_t rxState_reg;

   logic [7:0]  txMem_reg [MEM_DEPTH];
   logic [9:0]  txLen_reg;
   logic [9:0]  txIdx_reg;
   logic [7:0]  txSum_reg;
   logic        escSent_reg;
   logic [3:0]  nakCnt_reg;
   logic [3:0]  toCnt_reg;
   logic [3:0]  busyCnt_reg;
   logic [31:0] timer_reg;
   logic [7:0]  outData_reg;
   logic        outValid_reg;
   logic [1:0]  respPhase_reg;
   logic        respPend_reg;
   logic [7:0]  respCode_reg;
   logic        respRx_reg;
   logic [7:0]  respRxCode_reg;

   logic [7:0]  heldCode_reg;
   logic        rxEsc_reg;
   logic        rxEscErr_reg;
   logic [10:0] rxIdx_reg;
   logic [15:0] rxLen_reg;
   logic [7:0]  rxSum_reg;
   logic [7:0]  held_reg;

   logic        slotFree;
   logic        quiet;
   logic        sending;
   logic        stuffable;
   logic        txFire;
   logic        respStart;
   logic [7:0]  txField;
   logic        needEsc;
   logic [7:0]  txWord;
   logic [9:0]  loadCnt;
   logic [7:0]  bccValue;
   logic        timerDone;

   logic        rawTake;
   logic [7:0]  raw;
   logic        ubValid;
   logic [7:0]  ub;
   logic        escSet;
   logic        escBad;
   logic        endSeen;
   logic        restart;
   logic        pushNow;
   logic        lenBad;
   logic        sumBad;

   assign slotFree   = !outValid_reg || linkTxReady;
   assign quiet      = (txState_reg == TX_IDLE) || (txState_reg == TX_LOAD) ||
                       (txState_reg == TX_WAIT) || (txState_reg == TX_BUSYW);
   assign sending    = !quiet;
   assign stuffable  = (txState_reg == TX_LHI) || (txState_reg == TX_LLO) ||
                       (txState_reg == TX_MSG) || (txState_reg == TX_BCC);
   assign txFire     = sending && slotFree && (respPhase_reg == 2'h0);
   assign respStart  = respPend_reg && quiet && (respPhase_reg == 2'h0);
   assign loadCnt    = (txLen_reg == LEN_SAT) ? LEN_SAT : txLen_reg + 10'h001;
   assign bccValue   = txSum_reg + {6'h00, txLen_reg[9:8]} + txLen_reg[7:0];
   assign timerDone  = (timer_reg == 32'h0);
   assign txMsgReady = (txState_reg == TX_IDLE) || (txState_reg == TX_LOAD);

   assign linkTxData  = outData_reg;
   assign linkTxValid = outValid_reg;

   // Byte offered in the current field, before any escape is applied.
   always_comb begin
      case (txState_reg)
         TX_LHI:  txField = {6'h00, txLen_reg[9:8]};
         TX_LLO:  txField = txLen_reg[7:0];
         TX_MSG:  txField = txMem_reg[txIdx_reg[8:0]];
         TX_BCC:  txField = bccValue;
         TX_ETX:  txField = BYTE_END;
         default: txField = BYTE_START;
      endcase
   end

   always_comb begin
      needEsc = stuffable && ((txField == BYTE_START) || (txField == BYTE_END) ||
                              (txField == BYTE_ESC));
      if (needEsc && !escSent_reg) begin
         txWord = BYTE_ESC;
      end else if (needEsc && (txField == BYTE_START)) begin
         txWord = BYTE_ESC_START;
      end else if (needEsc && (txField == BYTE_END)) begin
         txWord = BYTE_ESC_END;
      end else begin
         txWord = txField;
      end
   end

   // One output stage feeds the serial unit; packet bytes and responses share it.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         outValid_reg <= 1'b0;
         outData_reg  <= 8'h00;
      end else if (txFire) begin
         outValid_reg <= 1'b1;
         outData_reg  <= txWord;
      end else if ((respPhase_reg != 2'h0) && slotFree) begin
         outValid_reg <= 1'b1;
         outData_reg  <= (respPhase_reg == 2'h1) ? respCode_reg : BYTE_END;
      end else if (linkTxReady) begin
         outValid_reg <= 1'b0;
      end
   end

   // A response waits for the end of any packet being sent, then goes out whole.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         respPhase_reg <= 2'h0;
      end else if (respStart) begin
         respPhase_reg <= 2'h1;
      end else if ((respPhase_reg == 2'h1) && slotFree) begin
         respPhase_reg <= 2'h2;
      end else if ((respPhase_reg == 2'h2) && slotFree) begin
         respPhase_reg <= 2'h0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (txMsgReady && txMsgValid) begin
         txMem_reg[(txState_reg == TX_IDLE) ? 9'h000 : txLen_reg[8:0]] <= txMsgData;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         timer_reg <= 32'h0;
      end else if ((txState_reg == TX_ETX) && txFire) begin
         timer_reg <= RespWaitCyc - 32'h1;
      end else if ((txState_reg == TX_WAIT) && respRx_reg && (respRxCode_reg == BYTE_BUSY)) begin
         timer_reg <= BusyWaitCyc - 32'h1;
      end else if (!timerDone) begin
         timer_reg <= timer_reg - 32'h1;
      end
   end

   // Packet sender: load, frame, stuff, wait for an answer and retry.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         txState_reg <= TX_IDLE;
         txLen_reg   <= 10'h000;
         txIdx_reg   <= 10'h000;
         txSum_reg   <= 8'h00;
         escSent_reg <= 1'b0;
         nakCnt_reg  <= 4'h0;
         toCnt_reg   <= 4'h0;
         busyCnt_reg <= 4'h0;
         evSendDone  <= 1'b0;
         evSendFail  <= 1'b0;
      end else begin
         evSendDone <= 1'b0;
         evSendFail <= 1'b0;
         if (txFire && stuffable) begin
            escSent_reg <= needEsc && !escSent_reg;
         end
         case (txState_reg)
            TX_IDLE: begin
               if (txMsgValid) begin
                  txLen_reg   <= 10'h001;
                  txSum_reg   <= txMsgData;
                  nakCnt_reg  <= 4'h0;
                  toCnt_reg   <= 4'h0;
                  busyCnt_reg <= 4'h0;
                  if (txMsgLast) begin
                     evSendFail <= 1'b1;
                  end else begin
                     txState_reg <= TX_LOAD;
                  end
               end
            end
            TX_LOAD: begin
               if (txMsgValid) begin
                  txLen_reg <= loadCnt;
                  txSum_reg <= txSum_reg + txMsgData;
                  if (txMsgLast) begin
                     if ((loadCnt < MSG_MIN) || (loadCnt > MSG_MAX)) begin
                        evSendFail  <= 1'b1;
                        txState_reg <= TX_IDLE;
                     end else begin
                        txState_reg <= TX_STX;
                     end
                  end
               end
            end
            TX_STX: begin
               if (txFire) begin
                  txState_reg <= TX_LHI;
               end
            end
            TX_LHI: begin
               if (txFire && !(needEsc && !escSent_reg)) begin
                  txState_reg <= TX_LLO;
               end
            end
            TX_LLO: begin
               if (txFire && !(needEsc && !escSent_reg)) begin
                  txIdx_reg   <= 10'h000;
                  txState_reg <= TX_MSG;
               end
            end
            TX_MSG: begin
               if (txFire && !(needEsc && !escSent_reg)) begin
                  txIdx_reg <= txIdx_reg + 10'h001;
                  if (txIdx_reg == txLen_reg - 10'h001) begin
                     txState_reg <= TX_BCC;
                  end
               end
            end
            TX_BCC: begin
               if (txFire && !(needEsc && !escSent_reg)) begin
                  txState_reg <= TX_ETX;
               end
            end
            TX_ETX: begin
               if (txFire) begin
                  txState_reg <= TX_WAIT;
               end
            end
            TX_WAIT: begin
               if (respRx_reg) begin
                  if (respRxCode_reg == BYTE_ACK) begin
                     evSendDone  <= 1'b1;
                     txState_reg <= TX_IDLE;
                  end else if (respRxCode_reg == BYTE_NAK) begin
                     if (nakCnt_reg < NakRetries) begin
                        nakCnt_reg  <= nakCnt_reg + 4'h1;
                        txState_reg <= TX_STX;
                     end else begin
                        evSendFail  <= 1'b1;
                        txState_reg <= TX_IDLE;
                     end
                  end else if (busyCnt_reg < BusyRetries) begin
                     busyCnt_reg <= busyCnt_reg + 4'h1;
                     txState_reg <= TX_BUSYW;
                  end else begin
                     evSendFail  <= 1'b1;
                     txState_reg <= TX_IDLE;
                  end
               end else if (timerDone) begin
                  if (toCnt_reg < TimeoutRetries) begin
                     toCnt_reg   <= toCnt_reg + 4'h1;
                     txState_reg <= TX_STX;
                  end else begin
                     evSendFail  <= 1'b1;
                     txState_reg <= TX_IDLE;
                  end
               end
            end
            TX_BUSYW: begin
               if (timerDone) begin
                  txState_reg <= TX_STX;
               end
            end
            default: txState_reg <= TX_IDLE;
         endcase
      end
   end

   // Receive side decode; the buffer's ready throttles the whole link input.
   assign linkRxReady  = bufIn.ready;
   assign raw          = linkRxData;
   assign rawTake      = linkRxValid && linkRxReady;
   assign bufIn.data   = held_reg;
   assign bufIn.valid  = pushNow;
   assign rxMsgData    = bufOut.data;
   assign rxMsgValid   = bufOut.valid;
   assign bufOut.ready = rxMsgReady;

   always_comb begin
      ubValid = 1'b0;
      ub      = raw;
      escSet  = 1'b0;
      escBad  = 1'b0;
      endSeen = 1'b0;
      restart = 1'b0;
      if ((rxState_reg == RX_BODY) && rawTake) begin
         if (rxEsc_reg) begin
            if (raw == BYTE_ESC_START) begin
               ubValid = 1'b1;
               ub      = BYTE_START;
            end else if (raw == BYTE_ESC_END) begin
               ubValid = 1'b1;
               ub      = BYTE_END;
            end else if (raw == BYTE_ESC) begin
               ubValid = 1'b1;
            end else begin
               escBad  = 1'b1;
               endSeen = (raw == BYTE_END);
            end
         end else if (raw == BYTE_ESC) begin
            escSet = 1'b1;
         end else if (raw == BYTE_END) begin
            endSeen = 1'b1;
         end else if (raw == BYTE_START) begin
            restart = 1'b1;
         end else begin
            ubValid = 1'b1;
         end
      end
      pushNow = ubValid && (rxIdx_reg >= RX_HDR);
   end

   // The last unstuffed byte before the end byte is the checksum, so one is held back.
   assign lenBad = (rxIdx_reg < RX_HDR) ||
                   ({5'h00, rxIdx_reg - RX_HDR} != rxLen_reg) ||
                   (rxLen_reg < {6'h00, MSG_MIN}) || (rxLen_reg > {6'h00, MSG_MAX});
   assign sumBad = (held_reg != rxSum_reg);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rxState_reg  <= RX_HUNT;
         rxEsc_reg    <= 1'b0;
         rxEscErr_reg <= 1'b0;
         rxIdx_reg    <= 11'h000;
         rxLen_reg    <= 16'h0000;
         rxSum_reg    <= 8'h00;
         held_reg     <= 8'h00;
         heldCode_reg <= 8'h00;
      end else if (rawTake) begin
         case (rxState_reg)
            RX_BODY: begin
               if (restart || endSeen) begin
                  rxState_reg <= restart ? RX_BODY : RX_HUNT;
                  rxEsc_reg    <= 1'b0;
                  rxEscErr_reg <= 1'b0;
                  rxIdx_reg    <= 11'h000;
                  rxSum_reg    <= 8'h00;
               end else begin
                  rxEsc_reg <= escSet;
                  if (escBad) begin
                     rxEscErr_reg <= 1'b1;
                  end
                  if (ubValid) begin
                     rxIdx_reg <= (rxIdx_reg == RX_SAT) ? RX_SAT : rxIdx_reg + 11'h001;
                     held_reg  <= ub;
                     if (rxIdx_reg == 11'h000) begin
                        rxLen_reg[15:8] <= ub;
                        rxSum_reg       <= ub;
                     end else if (rxIdx_reg == 11'h001) begin
                        rxLen_reg[7:0] <= ub;
                        rxSum_reg      <= rxSum_reg + ub;
                     end else if (pushNow) begin
                        rxSum_reg <= rxSum_reg + held_reg;
                     end
                  end
               end
            end
            default: begin
               if (raw == BYTE_START) begin
                  rxState_reg  <= RX_BODY;
                  rxEsc_reg    <= 1'b0;
                  rxEscErr_reg <= 1'b0;
                  rxIdx_reg    <= 11'h000;
                  rxSum_reg    <= 8'h00;
               end else if ((raw == BYTE_ACK) || (raw == BYTE_NAK) || (raw == BYTE_BUSY)) begin
                  rxState_reg  <= RX_RESP;
                  heldCode_reg <= raw;
               end else begin
                  rxState_reg <= RX_HUNT;
               end
            end
         endcase
      end
   end

   // Responses are passed on only when the end byte follows the code directly.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         respRx_reg     <= 1'b0;
         respRxCode_reg <= 8'h00;
      end else begin
         respRx_reg <= rawTake && (rxState_reg == RX_RESP) && (raw == BYTE_END);
         if (rawTake && (rxState_reg == RX_RESP)) begin
            respRxCode_reg <= heldCode_reg;
         end
      end
   end

   // A fresh packet end wins over the clear by a starting response.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         respPend_reg  <= 1'b0;
         respCode_reg  <= BYTE_ACK;
         evRxGood      <= 1'b0;
         evChecksumErr <= 1'b0;
         evLengthErr   <= 1'b0;
         evEscapeErr   <= 1'b0;
      end else begin
         evRxGood      <= 1'b0;
         evChecksumErr <= 1'b0;
         evLengthErr   <= 1'b0;
         evEscapeErr   <= 1'b0;
         if (endSeen) begin
            respPend_reg  <= 1'b1;
            respCode_reg  <= (lenBad || sumBad || rxEscErr_reg || escBad) ? BYTE_NAK : BYTE_ACK;
            evRxGood      <= !(lenBad || sumBad || rxEscErr_reg || escBad);
            evChecksumErr <= sumBad;
            evLengthErr   <= lenBad;
            evEscapeErr   <= rxEscErr_reg || escBad;
         end else if (respStart) begin
            respPend_reg <= 1'b0;
         end
      end
   end

endmodule

// [rtl/spf_pkg.sv]
// Purpose: Shared constants and types for the serial packet framer.
// Assumes: One system clock at the rate given by CLK_HZ.
// Notes:   Timing counts are derived from the rate and the printed seconds.
package spf_pkg;

   localparam logic [7:0] BYTE_START     = 8'h02;
   localparam logic [7:0] BYTE_END       = 8'h03;
   localparam logic [7:0] BYTE_ACK       = 8'h06;
   localparam logic [7:0] BYTE_NAK       = 8'h15;
   localparam logic [7:0] BYTE_BUSY      = 8'h1A;
   localparam logic [7:0] BYTE_ESC       = 8'hFF;
   localparam logic [7:0] BYTE_ESC_START = 8'hF2;
   localparam logic [7:0] BYTE_ESC_END   = 8'hF3;

   localparam logic [9:0]  MSG_MIN   = 10'h006;
   localparam logic [9:0]  MSG_MAX   = 10'h1FB;
   localparam logic [9:0]  LEN_SAT   = 10'h3FF;
   localparam logic [10:0] RX_HDR    = 11'h003;
   localparam logic [10:0] RX_SAT    = 11'h7FF;
   localparam int          MEM_DEPTH = 32'h200;

   localparam int CLK_HZ         = 32'h0773_5940;
   localparam int RESP_TIMEOUT_S = 32'h5;
   localparam int BUSY_DELAY_S   = 32'hA;
   localparam int RESP_WAIT_CYC  = CLK_HZ * RESP_TIMEOUT_S;
   localparam int BUSY_WAIT_CYC  = CLK_HZ * BUSY_DELAY_S;

   localparam logic [3:0] NAK_RETRIES     = 4'h3;
   localparam logic [3:0] TIMEOUT_RETRIES = 4'h3;
   localparam logic [3:0] BUSY_RETRIES    = 4'hA;

   typedef enum logic [3:0] {
      TX_IDLE  = 4'h0,
      TX_LOAD  = 4'h1,
      TX_STX   = 4'h3,
      TX_LHI   = 4'h2,
      TX_LLO   = 4'h6,
      TX_MSG   = 4'h7,
      TX_BCC   = 4'h5,
      TX_ETX   = 4'h4,
      TX_WAIT  = 4'hC,
      TX_BUSYW = 4'hD
   } spf_tx_state_t;

   typedef enum logic [1:0] {
      RX_HUNT = 2'h0,
      RX_RESP = 2'h1,
      RX_BODY = 2'h3
   } spf_rx_state_t;

endpackage

// [rtl/spf_byte_if.sv]
// Purpose: Valid/ready byte carrier between the framer and its buffer.
// Assumes: Source holds data stable while valid is high and ready is low.
// Notes:   A word moves on a clock edge with valid and ready both high.
`timescale 1ns/1ps
interface spf_byte_if #(parameter int W = 8) ();
   logic [W-1:0] data;
   logic         valid;
   logic         ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// [rtl/spf_pair_buf.sv]
// Purpose: Small FIFO that absorbs a stall of the receiving user.
// Assumes: DEPTH is a power of two, two by default.
// Notes:   Output data comes straight from the storage flip-flops.
`timescale 1ns/1ps
module spf_pair_buf #(
   parameter int W     = 8,
   parameter int DEPTH = 2
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   spf_byte_if.snk  inSide,
   spf_byte_if.src  outSide
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   logic [W-1:0]  mem_reg [DEPTH];
   logic [AW-1:0] wrPtr_reg;
   logic [AW-1:0] rdPtr_reg;
   logic [AW:0]   cnt_reg;
   logic          doPush;
   logic          doPop;

   assign inSide.ready  = (cnt_reg != FULL);
   assign outSide.valid = (cnt_reg != '0);
   assign outSide.data  = mem_reg[rdPtr_reg];
   assign doPush        = inSide.valid && inSide.ready;
   assign doPop         = outSide.valid && outSide.ready;

   always_ff @(posedge clk_sys) begin
      if (doPush) begin
         mem_reg[wrPtr_reg] <= inSide.data;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         cnt_reg   <= '0;
      end else begin
         if (doPush) begin
            wrPtr_reg <= (wrPtr_reg == LAST) ? '0 : wrPtr_reg + 1'b1;
         end
         if (doPop) begin
            rdPtr_reg <= (rdPtr_reg == LAST) ? '0 : rdPtr_reg + 1'b1;
         end
         if (doPush && !doPop) begin
            cnt_reg <= cnt_reg + 1'b1;
         end else if (doPop && !doPush) begin
            cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end
endmodule

// [dv/spf_framer_chk.sv]
// Purpose: Port assertions for spf_framer.
// Assumes: rst_b low clears the block.
// Notes:   Bound to every instance.
`timescale 1ns/1ps
module spf_framer_chk (
   input wire logic       clk_sys,
   input wire logic       rst_b,
   input wire logic [7:0] linkTxData,
   input wire logic       linkTxValid,
   input wire logic       linkTxReady,
   input wire logic       linkRxReady,
   input wire logic [7:0] rxMsgData,
   input wire logic       rxMsgValid,
   input wire logic       rxMsgReady,
   input wire logic       txMsgReady,
   input wire logic       evSendDone,
   input wire logic       evSendFail
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   logic escReg;
   wire  tk = linkTxValid && linkTxReady;
   // Marks the first byte of an escape pair.
   always_ff @(posedge clk_sys or negedge rst_b)
      if (!rst_b) escReg <= 1'b0;
      else if (tk) escReg <= !escReg && linkTxData == 8'hFF;
   a_esc_pair: assert property (tk && escReg |-> linkTxData inside {8'hF2, 8'hF3, 8'hFF})
      else $error("bad escape");
   a_tx_hold: assert property (linkTxValid && !linkTxReady |=> linkTxValid && $stable(linkTxData))
      else $error("tx hold");
   a_ev_pulse: assert property (evSendDone || evSendFail |=> !evSendDone && !evSendFail)
      else $error("event long");
   a_one_verdict: assert property (!(evSendDone && evSendFail)) else $error("done with fail");
   a_rx_hold: assert property (rxMsgValid && !rxMsgReady |=> rxMsgValid && $stable(rxMsgData))
      else $error("rx hold");
   a_fail_idle: assert property (evSendFail |=> txMsgReady) else $error("fail busy");
   a_done_idle: assert property (evSendDone |=> txMsgReady) else $error("done busy");
   a_full_valid: assert property (!linkRxReady |-> rxMsgValid) else $error("full but empty");
endmodule
bind spf_framer spf_framer_chk i_spf_framer_chk (.*);

// [dv/spf_link_peer.sv]
// Purpose: Controller model on the link side.
// Assumes: The bench fills toDut.
// Notes:   Refuses one byte in four.
`timescale 1ns/1ps
module spf_link_peer (
   input  wire logic       clk_sys,
   input  wire logic [7:0] linkTxData,
   input  wire logic       linkTxValid,
   output logic            linkTxReady,
   output logic [7:0]      linkRxData,
   output logic            linkRxValid,
   input  wire logic       linkRxReady
);
   logic [1:0] cnt = 2'h0;
   logic [7:0] toDut[$];
   logic [7:0] seen[$];
   initial linkRxData = 8'h00;
   initial linkRxValid = 1'b0;
   assign linkTxReady = cnt != 2'h3;
   // Idle data inverts on every clock, starting from the last byte.
   always @(posedge clk_sys) begin
      cnt <= cnt + 2'h1;
      if (linkTxValid && linkTxReady) seen.push_back(linkTxData);
      if (!linkRxValid || linkRxReady) begin
         linkRxValid <= toDut.size() > 0;
         linkRxData <= toDut.size() > 0 ? toDut.pop_front() : ~linkRxData;
      end
   end
endmodule

// [dv/test_spf_framer.sv]
// Purpose: Self-checking bench for spf_framer.
// Assumes: Waits of 200 and 300 cycles.
// Notes:   The user side stalls every other cycle.
`timescale 1ns/1ps
module test_spf_framer;
   logic       clk_sys = 1'b0;
   logic       rst_b = 1'b0;
   logic [7:0] txMsgData = 8'h00;
   logic       txMsgValid = 1'b0;
   logic       txMsgLast = 1'b0;
   logic       rxMsgReady = 1'b0;
   wire  [7:0] linkTxData, linkRxData, rxMsgData;
   wire        linkTxValid, linkTxReady, linkRxValid, linkRxReady, rxMsgValid, txMsgReady;
   wire  [5:0] evs;
   logic [5:0] ev = 6'h00;
   int         n_fail = 0;
   int         checked = 0;
   logic [7:0] got[$];
   logic [103:0] pk;
   logic [47:0]  m = 48'h0203FF102030;
   logic [111:0] tx = 112'h020006FFF2FFF3FFFF1020306A03;
   // Row: length low, escaped byte, checksum, good/sum/length/escape events.
   logic [27:0]  rw[4] = '{28'h06F2678, 28'h06F2724, 28'h07F2722, 28'h0601711};
   always #4 clk_sys = !clk_sys;
   spf_framer #(.RespWaitCyc(200), .BusyWaitCyc(300)) i_spf_framer (.*, .evSendDone(evs[4]),
      .evSendFail(evs[5]), .evRxGood(evs[3]), .evChecksumErr(evs[2]), .evLengthErr(evs[1]), .evEscapeErr(evs[0]));
   spf_link_peer peer (.*);
   always @(posedge clk_sys) begin
      ev <= ev | evs;
      rxMsgReady <= !rxMsgReady;
      if (rxMsgValid && rxMsgReady) got.push_back(rxMsgData);
   end
   function automatic logic [7:0] sn(input int i);
      return peer.seen[i];
   endfunction
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic clr();
      @(negedge clk_sys) ev = 6'h00;
      peer.seen.delete();
      got.delete();
      @(posedge clk_sys);
   endtask
   task automatic rsp(input logic [7:0] c);
      peer.toDut.push_back(c);
      peer.toDut.push_back(8'h03);
   endtask
   task automatic wt(input int s, input int b, input int lim);
      for (int k = 0; k < lim && peer.seen.size() < s && ev[b] !== 1'b1; k++) @(posedge clk_sys);
   endtask
   task automatic txm(input int n);
      for (int i = 0; i < n; i++) begin
         txMsgData <= m[47 - 8 * i -: 8];
         txMsgValid <= 1'b1;
         txMsgLast <= i == n - 1;
         do @(negedge clk_sys); while (txMsgReady !== 1'b1);
         @(posedge clk_sys);
      end
      txMsgValid <= 1'b0;
      txMsgLast <= 1'b0;
   endtask
   task automatic summarize();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      summarize();
   end
   initial begin
      repeat (16) @(posedge clk_sys);
      chk("txMsgReady", 8'h01, txMsgReady);
      chk("linkTxValid", 8'h00, linkTxValid);
      rst_b <= 1'b1;
      for (int r = 0; r < 4; r++) begin
         clr();
         pk = {24'h550200, rw[r][27:20], 8'hFF, rw[r][19:12], 40'h1112131415, rw[r][11:4], 8'h03};
         for (int j = 96; j >= 0; j -= 8) peer.toDut.push_back(pk[j +: 8]);
         wt(2, 4, 3000);
         repeat (8) @(posedge clk_sys);
         chk("rx events", {4'h0, rw[r][3:0]}, {4'h0, ev[3:0] & rw[r][3:0]});
         chk("response", rw[r][3] ? 8'h06 : 8'h15, sn(0));
         chk("response end", 8'h03, sn(1));
         if (r == 0) chk("rx count", 8'h06, 8'(got.size()));
         if (r == 0) chk("rx first", 8'h02, got[0]);
         $display("rx row %0d done", r);
      end
      clr();
      txm(6);
      wt(14, 4, 3000);
      for (int j = 0; j < 14; j++) chk("tx byte", tx[111 - 8 * j -: 8], sn(j));
      rsp(8'h06);
      wt(99, 4, 100);
      chk("done", 8'h01, ev[4]);
      $display("tx ack done");
      clr();
      txm(6);
      for (int k = 1; k < 5; k++) begin
         wt(14 * k, 4, 3000);
         rsp(8'h15);
      end
      wt(99, 5, 300);
      chk("nak fail", 8'h01, ev[5]);
      chk("nak sends", 8'h38, 8'(peer.seen.size()));
      clr();
      txm(6);
      wt(99, 5, 3000);
      chk("timeout sends", 8'h38, 8'(peer.seen.size()));
      rsp(8'h06);
      repeat (20) @(posedge clk_sys);
      chk("late ack", 8'h00, ev[4]);
      clr();
      txm(1);
      wt(99, 5, 20);
      chk("short sends", 8'h00, 8'(peer.seen.size()));
      $display("retry tests done");
      summarize();
   end
endmodule
